// >>> design/drop_event_status.sv
// Drop event status: two drop records, mask, event interrupt, AXI4-Lite.
// Assumes drop events and bus signals are synchronous to clk.
//
// Function
// - Mask bit 0 set suppresses drop interrupt; resets to one.
// - Clearing mask re-enables interrupt for any pending valid record.
// - Mask never affects recording, holding or clearing of records.
// - Two records A and B hold two drops at once; B fills only while A is valid.
// - Record A valid at bit 0, fields 6:1, all clear on read.
// - Record A reason code in bits 6:3, same codes as B.
// - Record A port in bits 2:1: ports 0,1,2; code 11 reserved.
// - Record B valid at bit 7, fields 13:8, all clear on read.
// - Record B reason in bits 13:10, port in bits 9:8.
// - Code 0000: lookup miss dropped over broadcast buffer level.
// - Code 0001: red packet dropped with discard-on-red enabled.
// - Code 0010: no free buffer; code 0011: no free descriptor.
// - Code 0100: lookup miss with no valid destination port.
// - Code 0101: receive error on packet longer than 64 bytes.
// - Code 0110: general buffer drop level exceeded.
// - Code 1001: yellow packet randomly dropped, discard-on-yellow on.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps

module drop_event_status
  import drop_status_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                ce,
  // Drop event from the buffer manager
  input  wire logic                dropValid,
  input  wire logic [REASON_W-1:0] dropReason,
  input  wire logic [PORT_W-1:0]   dropPort,
  // AXI4-Lite write address
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]          awprot,
  // AXI4-Lite write data
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic [STRB_W-1:0]   wstrb,
  // AXI4-Lite write response
  output logic                     bvalid,
  input  wire logic                bready,
  output logic [1:0]               bresp,
  // AXI4-Lite read address
  input  wire logic                arvalid,
  output logic                     arready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic [2:0]          arprot,
  // AXI4-Lite read data
  output logic                     rvalid,
  input  wire logic                rready,
  output logic [DATA_W-1:0]        rdata,
  output logic [1:0]               rresp,
  // Interrupts
  output logic                     dropIrq,
  output logic                     eventIrq
);

  // ********************************************************************
  // Address decode
  // ********************************************************************
  function automatic reg_sel_type decodeAddr(
    input logic [ADDR_W-1:0] addr
  );
    reg_sel_type sel;
    sel = SEL_NONE;
    if (addr == (MASK_INDEX << INDEX_SHIFT)) begin
      sel = SEL_MASK;
    end else if (addr == (PENDING_INDEX << INDEX_SHIFT)) begin
      sel = SEL_PENDING;
    end else if (addr == (EVSTAT_INDEX << INDEX_SHIFT)) begin
      sel = SEL_EVSTAT;
    end else if (addr == (EVCLEAR_INDEX << INDEX_SHIFT)) begin
      sel = SEL_EVCLEAR;
    end else if (addr == (EVENBL_INDEX << INDEX_SHIFT)) begin
      sel = SEL_EVENBL;
    end
    return sel;
  endfunction : decodeAddr

  // ********************************************************************
  // Reason code legality
  // ********************************************************************
  function automatic logic legalReason(
    input logic [REASON_W-1:0] code
  );
    logic ok;
    ok = 1'b0;
    unique case (code)
      RSN_BCAST_LEVEL: ok = 1'b1;
      RSN_RED:         ok = 1'b1;
      RSN_NO_BUFFER,
      RSN_NO_DESCR:    ok = 1'b1;
      RSN_NO_DEST:     ok = 1'b1;
      RSN_RX_ERROR:    ok = 1'b1;
      RSN_DROP_LEVEL:  ok = 1'b1;
      RSN_YELLOW:      ok = 1'b1;
      default:         ok = 1'b0;
    endcase
    return ok;
  endfunction : legalReason

  // ********************************************************************
  // State
  // ********************************************************************
  logic              maskBit;
  logic              validA;
  logic              validB;
  drop_record_type   recA;
  drop_record_type   recB;
  logic [EV_W-1:0]   evStatus;
  logic [EV_W-1:0]   evEnable;
  logic [ADDR_W-1:0] awAddrHeld;
  logic [DATA_W-1:0] wDataHeld;
  logic [STRB_W-1:0] wStrbHeld;

  // ********************************************************************
  // Bus handshakes
  // ********************************************************************
  logic              awFire;
  logic              wFire;
  logic              arFire;
  logic              doWrite;
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] wrData;
  logic [STRB_W-1:0] wrStrb;
  reg_sel_type       wrSel;
  reg_sel_type       rdSel;

  assign awFire  = awvalid & awready;
  assign wFire   = wvalid & wready;
  assign arFire  = arvalid & arready;
  assign doWrite = ~bvalid & (awFire | ~awready) & (wFire | ~wready);
  assign wrAddr  = awFire ? awaddr : awAddrHeld;
  assign wrData  = wFire ? wdata : wDataHeld;
  assign wrStrb  = wFire ? wstrb : wStrbHeld;
  assign wrSel   = decodeAddr(wrAddr);
  assign rdSel   = decodeAddr(araddr);

  // ********************************************************************
  // Register write decode
  // ********************************************************************
  // Byte lane 0 carries every live bit
  logic              wrMask;
  logic              wrEvClear;
  logic              wrEvEnable;

  assign wrMask     = doWrite & (wrSel == SEL_MASK) & wrStrb[0];
  assign wrEvClear  = doWrite & (wrSel == SEL_EVCLEAR) & wrStrb[0];
  assign wrEvEnable = doWrite & (wrSel == SEL_EVENBL) & wrStrb[0];

  // ********************************************************************
  // Record allocation
  // ********************************************************************
  logic            readClear;
  logic            eventOk;
  logic            keptA;
  logic            keptB;
  logic            fillA;
  logic            fillB;
  logic            lostEvent;
  drop_record_type incoming;

  assign readClear = ce & arFire & (rdSel == SEL_PENDING);
  assign eventOk   = ce & dropValid & legalReason(dropReason)
                     & (dropPort != PORT_RESERVED);
  assign incoming  = '{reason: dropReason, port: dropPort};
  // Clear first, so an event in the read cycle still lands
  assign keptA     = validA & ~readClear;
  assign keptB     = validB & ~readClear;
  assign fillA     = eventOk & ~keptA;
  assign fillB     = eventOk & keptA & ~keptB;
  assign lostEvent = eventOk & keptA & keptB;

  // ********************************************************************
  // Drop records
  // ********************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      validA <= 1'b0;
      recA   <= '0;
    end else if (ce) begin
      if (fillA) begin
        validA <= 1'b1;
        recA   <= incoming;
      end else if (readClear) begin
        validA <= 1'b0;
        recA   <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      validB <= 1'b0;
      recB   <= '0;
    end else if (ce) begin
      if (fillB) begin
        validB <= 1'b1;
        recB   <= incoming;
      end else if (readClear) begin
        validB <= 1'b0;
        recB   <= '0;
      end
    end
  end

  // ********************************************************************
  // Mask register
  // ********************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      maskBit <= MASK_RESET;
    end else if (ce && wrMask) begin
      maskBit <= wrData[MASK_BIT];
    end
  end

  // ********************************************************************
  // Event status, enable and clear
  // ********************************************************************
  logic [EV_W-1:0] evSet;
  logic [EV_W-1:0] evClr;

  assign evSet[EV_RECORDED] = fillA | fillB;
  assign evSet[EV_LOST]     = lostEvent;
  assign evClr = wrEvClear ? wrData[EV_W-1:0] : EV_RESET;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evStatus <= EV_RESET;
    end else if (ce) begin
      evStatus <= (evStatus & ~evClr) | evSet;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evEnable <= EV_RESET;
    end else if (ce && wrEvEnable) begin
      evEnable <= wrData[EV_W-1:0];
    end
  end

  // ********************************************************************
  // Interrupt outputs
  // ********************************************************************
  logic next_dropIrq;
  logic next_eventIrq;
  logic next_validA;
  logic next_validB;
  logic next_mask;

  assign next_validA  = fillA | keptA;
  assign next_validB  = fillB | keptB;
  assign next_mask    = wrMask ? wrData[MASK_BIT] : maskBit;
  assign next_dropIrq = (next_validA | next_validB) & ~next_mask;
  assign next_eventIrq = |(((evStatus & ~evClr) | evSet) & evEnable);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dropIrq  <= 1'b0;
      eventIrq <= 1'b0;
    end else if (ce) begin
      dropIrq  <= next_dropIrq;
      eventIrq <= next_eventIrq;
    end
  end

  // ********************************************************************
  // Write channels
  // ********************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awready    <= 1'b1;
      awAddrHeld <= '0;
    end else if (ce) begin
      if (awFire) begin
        awready    <= 1'b0;
        awAddrHeld <= awaddr;
      end else if (bvalid && bready) begin
        awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wready    <= 1'b1;
      wDataHeld <= '0;
      wStrbHeld <= '0;
    end else if (ce) begin
      if (wFire) begin
        wready    <= 1'b0;
        wDataHeld <= wdata;
        wStrbHeld <= wstrb;
      end else if (bvalid && bready) begin
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Read channel
  // ********************************************************************
  logic [DATA_W-1:0] readValue;

  always_comb begin
    readValue = '0;
    unique case (rdSel)
      SEL_MASK: begin
        readValue[MASK_BIT] = maskBit;
      end
      SEL_PENDING: begin
        readValue[A_VALID_BIT] = validA;
        readValue[A_PORT_LSB +: PORT_W] = recA.port;
        readValue[A_REASON_LSB +: REASON_W] = recA.reason;
        readValue[B_VALID_BIT] = validB;
        readValue[B_PORT_LSB +: PORT_W] = recB.port;
        readValue[B_REASON_LSB +: REASON_W] = recB.reason;
      end
      SEL_EVSTAT: begin
        readValue[EV_W-1:0] = evStatus;
      end
      SEL_EVENBL: begin
        readValue[EV_W-1:0] = evEnable;
      end
      SEL_EVCLEAR,
      SEL_NONE: begin
        readValue = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (arFire) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= readValue;
        rresp   <= (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid && rready) begin
        arready <= 1'b1;
        rvalid  <= 1'b0;
      end
    end
  end

endmodule : drop_event_status

// >>> pkg/drop_status_pkg.sv
// Constants, types and register map of the drop event status block.
// Assumes an AXI4-Lite master with 32-bit data and one 20 MHz clock.
package drop_status_pkg;

  // ********************************************************************
  // Bus widths
  // ********************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // ********************************************************************
  // Register indices and byte addresses
  // ********************************************************************
  localparam logic [ADDR_W-1:0] MASK_INDEX    = 16'h1c20;
  localparam logic [ADDR_W-1:0] PENDING_INDEX = 16'h1c21;
  localparam logic [ADDR_W-1:0] EVSTAT_INDEX  = 16'h1c22;
  localparam logic [ADDR_W-1:0] EVCLEAR_INDEX = 16'h1c23;
  localparam logic [ADDR_W-1:0] EVENBL_INDEX  = 16'h1c24;
  localparam int               INDEX_SHIFT   = 2;

  // ********************************************************************
  // Field layout and reset values
  // ********************************************************************
  localparam int REASON_W       = 4;
  localparam int PORT_W         = 2;
  localparam int MASK_BIT       = 0;
  localparam int A_VALID_BIT    = 0;
  localparam int A_PORT_LSB     = 1;
  localparam int A_REASON_LSB   = 3;
  localparam int B_VALID_BIT    = 7;
  localparam int B_PORT_LSB     = 8;
  localparam int B_REASON_LSB   = 10;
  localparam int EV_W           = 2;
  localparam int EV_RECORDED    = 0;
  localparam int EV_LOST        = 1;
  localparam logic MASK_RESET   = 1'b1;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;

  // ********************************************************************
  // Drop reason codes and port codes
  // ********************************************************************
  localparam logic [REASON_W-1:0] RSN_BCAST_LEVEL = 4'h0;
  localparam logic [REASON_W-1:0] RSN_RED         = 4'h1;
  localparam logic [REASON_W-1:0] RSN_NO_BUFFER   = 4'h2;
  localparam logic [REASON_W-1:0] RSN_NO_DESCR    = 4'h3;
  localparam logic [REASON_W-1:0] RSN_NO_DEST     = 4'h4;
  localparam logic [REASON_W-1:0] RSN_RX_ERROR    = 4'h5;
  localparam logic [REASON_W-1:0] RSN_DROP_LEVEL  = 4'h6;
  localparam logic [REASON_W-1:0] RSN_YELLOW      = 4'h9;
  localparam logic [PORT_W-1:0]   PORT_RESERVED   = 2'h3;

  // ********************************************************************
  // AXI responses
  // ********************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic [REASON_W-1:0] reason;
    logic [PORT_W-1:0]   port;
  } drop_record_type;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_MASK,
    SEL_PENDING,
    SEL_EVSTAT,
    SEL_EVCLEAR,
    SEL_EVENBL
  } reg_sel_type;

endpackage : drop_status_pkg

// >>> testbench/drop_status_chk.sv
// Checker: drop interrupt level and pending read layout.
// Assumes binding to drop_event_status; sees its ports only.
`timescale 1ns/1ps
module drop_status_chk
  import drop_status_pkg::*;
(
  // Clock and reset
  input logic                clk,
  input logic                arst_n,
  input logic                ce,
  // Drop event
  input logic                dropValid,
  input logic [REASON_W-1:0] dropReason,
  input logic [PORT_W-1:0]   dropPort,
  // Register bus
  input logic                awvalid,
  input logic                awready,
  input logic [ADDR_W-1:0]   awaddr,
  input logic                wvalid,
  input logic                wready,
  input logic [DATA_W-1:0]   wdata,
  input logic [STRB_W-1:0]   wstrb,
  input logic                bvalid,
  input logic                bready,
  input logic                arvalid,
  input logic                arready,
  input logic [ADDR_W-1:0]   araddr,
  input logic                rvalid,
  input logic [DATA_W-1:0]   rdata,
  // Interrupt
  input logic                dropIrq
);
  // ****
  // Mirror of mask and record state
  // ****
  logic              awHeld, wHeld, maskM, anyV, twoV, rdPend, strbL;
  logic [ADDR_W-1:0] awL;
  logic [DATA_W-1:0] wL;
  wire awHs = awvalid & awready & ce;
  wire wHs = wvalid & wready & ce;
  wire commit = (awHeld | awHs) & (wHeld | wHs) & ~bvalid;
  wire [ADDR_W-1:0] cAddr = awHs ? awaddr : awL;
  wire [DATA_W-1:0] cData = wHs ? wdata : wL;
  wire cStrb = wHs ? wstrb[0] : strbL;
  wire maskWr = commit & cStrb & (cAddr == (MASK_INDEX << INDEX_SHIFT));
  wire arHs = arvalid & arready & ce;
  wire pendRd = arHs & (araddr == (PENDING_INDEX << INDEX_SHIFT));
  wire legal = dropValid & ce & (dropPort != PORT_RESERVED)
    & (dropReason < 4'ha) & (dropReason != 4'h7) & (dropReason != 4'h8);

  always_ff @(posedge clk) begin
    if (awHs) awL <= awaddr;
    if (wHs) wL <= wdata;
    if (wHs) strbL <= wstrb[0];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      maskM <= MASK_RESET;
      anyV <= 1'b0;
      twoV <= 1'b0;
      rdPend <= 1'b0;
    end else begin
      awHeld <= (awHeld | awHs) & ~(bvalid & bready & ce);
      wHeld <= (wHeld | wHs) & ~(bvalid & bready & ce);
      if (maskWr) maskM <= cData[MASK_BIT];
      anyV <= legal | (anyV & ~pendRd);
      twoV <= ~pendRd & (twoV | (legal & anyV));
      if (arHs) rdPend <= pendRd;
    end
  end

  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_irq_level; dropIrq == (anyV & ~maskM); endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("drop irq level wrong");
  property p_masked; maskM |-> !dropIrq; endproperty
  a_masked: assert property (p_masked)
    else $error("drop irq while masked");
  property p_unmask; maskWr && !cData[0] && anyV && !pendRd |=> dropIrq;
  endproperty
  a_unmask: assert property (p_unmask)
    else $error("unmask did not raise irq");
  property p_read_a; pendRd |=> rvalid && rdata[0] == $past(anyV);
  endproperty
  a_read_a: assert property (p_read_a)
    else $error("record A valid lost");
  property p_a_fields;
    rvalid && rdPend && !rdata[0] |-> rdata[6:1] == 6'h0 && rdata[31:14] == 0;
  endproperty
  a_a_fields: assert property (p_a_fields)
    else $error("record A fields not clear");
  property p_b_fields; rvalid && rdPend && !rdata[7] |-> rdata[13:8] == 6'h0;
  endproperty
  a_b_fields: assert property (p_b_fields)
    else $error("record B fields not clear");
  property p_b_after_a; rvalid && rdPend && rdata[7] |-> rdata[0]; endproperty
  a_b_after_a: assert property (p_b_after_a)
    else $error("record B filled before A");
  property p_no_resv;
    rvalid && rdPend && rdata[0] |-> rdata[2:1] != 2'h3 && rdata[6:3] < 4'ha
      && rdata[6:3] != 4'h7 && rdata[6:3] != 4'h8;
  endproperty
  a_no_resv: assert property (p_no_resv)
    else $error("reserved code reported");
  property p_two; pendRd |=> rdata[7] == $past(twoV); endproperty
  a_two: assert property (p_two)
    else $error("record B valid wrong");
  c_unmask: cover property (maskWr && !cData[0] && anyV);
  c_both: cover property (rvalid && rdPend && rdata[7]);
  c_irq: cover property ($rose(dropIrq));
endmodule : drop_status_chk

bind drop_event_status drop_status_chk i_chk (
  .clk, .arst_n, .ce, .dropValid, .dropReason, .dropPort, .awvalid,
  .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
  .arvalid, .arready, .araddr, .rvalid, .rdata, .dropIrq
);

// >>> testbench/tb.sv
// Testbench: drop records, interrupts and register access.
// Assumes package, design and checker compiled first.
`timescale 1ns/1ps
module tb
  import drop_status_pkg::*;
;
  // ****
  // Signals
  // ****
  localparam logic [ADDR_W-1:0] A_MASK = MASK_INDEX << INDEX_SHIFT;
  localparam logic [ADDR_W-1:0] A_PEND = PENDING_INDEX << INDEX_SHIFT;
  localparam logic [ADDR_W-1:0] A_EVST = EVSTAT_INDEX << INDEX_SHIFT;
  localparam logic [ADDR_W-1:0] A_EVCL = EVCLEAR_INDEX << INDEX_SHIFT;
  localparam logic [ADDR_W-1:0] A_EVEN = EVENBL_INDEX << INDEX_SHIFT;
  logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, dropValid = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dropIrq, eventIrq;
  logic [REASON_W-1:0] dropReason = '0;
  logic [PORT_W-1:0]   dropPort = '0;
  logic [ADDR_W-1:0]   awaddr = '0, araddr = '0;
  logic [DATA_W-1:0]   wdata = '0, rdata, got, model = '0;
  logic [STRB_W-1:0]   wstrb = '0;
  logic [1:0]          bresp, rresp, resp;
  int                  mismatches = 0, nChecks = 0, cycles = 0, seed, n, mk;

  drop_event_status i_dut (
    .clk, .arst_n, .ce, .dropValid, .dropReason, .dropPort, .awvalid,
    .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
    .rvalid, .rready, .rdata, .rresp, .dropIrq, .eventIrq
  );
  always #25 clk = ~clk;

  // ****
  // Tasks
  // ****
  task automatic chk32(input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk32
  task automatic chk1(input logic e, input logic g);
    chk32({31'h0, e}, {31'h0, g});
  endtask : chk1
  function automatic logic [DATA_W-1:0] put(input logic [DATA_W-1:0] m,
      input logic [REASON_W-1:0] r, input logic [PORT_W-1:0] p);
    if (p == 2'h3 || r > 4'h9 || r == 4'h7 || r == 4'h8) return m;
    if (!m[0]) m[6:0] = {r, p, 1'b1};
    else if (!m[7]) m[13:7] = {r, p, 1'b1};
    return m;
  endfunction : put
  function automatic logic [1:0] rport();
    return 2'($unsigned($random(seed)) % 3);
  endfunction : rport
  task automatic axw(input logic [15:0] a, input logic [31:0] d,
      input logic [3:0] s);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : axw
  task automatic axr(input logic [15:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axr
  task automatic drop(input logic [3:0] r, input logic [1:0] p, input bit last);
    dropValid <= 1'b1;
    dropReason <= r;
    dropPort <= p;
    @(posedge clk);
    model = put(model, r, p);
    if (last) begin
      dropValid <= 1'b0;
      @(posedge clk);
    end
  endtask : drop
  task automatic readPend;
    axr(A_PEND);
    chk32(model, got);
    chk32(32'(RESP_OKAY), 32'(resp));
    model = '0;
  endtask : readPend
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // ****
  // Sequence
  // ****
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize;
    end
  end
  initial begin
    seed = 32'hc496;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    axr(A_MASK);
    chk32(32'h1, got);
    chk1(1'b0, dropIrq);
    readPend;
    axr(16'h7094);
    chk32(32'(RESP_SLVERR), 32'(resp));
    chk32(32'h0, got);
    axw(16'h7094, 32'h1, 4'hf);
    chk32(32'(RESP_SLVERR), 32'(resp));
    axw(A_MASK, 32'h0, 4'he);
    drop(RSN_RX_ERROR, 2'h2, 1'b1);
    chk1(1'b0, dropIrq);
    axw(A_PEND, 32'h0, 4'hf);
    chk32(32'(RESP_OKAY), 32'(resp));
    axw(A_MASK, 32'h0, 4'hf);
    chk1(1'b1, dropIrq);
    readPend;
    chk1(1'b0, dropIrq);
    for (int i = 0; i < 16; i++) begin
      drop(4'(i), rport(), 1'b0);
      drop(RSN_NO_BUFFER, PORT_RESERVED, 1'b0);
      drop(4'(15 - i), rport(), 1'b0);
      drop(RSN_RED, rport(), 1'b1);
      chk1(model[0], dropIrq);
      readPend;
    end
    repeat (40) begin
      n = $unsigned($random(seed)) % 4;
      for (int k = 0; k < n; k++)
        drop(4'($random(seed)), 2'($random(seed)), k == n - 1);
      mk = $random(seed) & 1;
      axw(A_MASK, 32'(mk), 4'hf);
      chk1(model[0] & ~mk[0], dropIrq);
      readPend;
    end
    axw(A_EVEN, 32'h1, 4'hf);
    axw(A_EVCL, 32'h3, 4'hf);
    chk1(1'b0, eventIrq);
    drop(RSN_YELLOW, 2'h1, 1'b1);
    chk1(1'b1, eventIrq);
    axr(A_EVST);
    chk32(32'h1, got);
    axw(A_EVCL, 32'h1, 4'hf);
    chk1(1'b0, eventIrq);
    axw(A_EVEN, 32'h0, 4'hf);
    drop(RSN_DROP_LEVEL, 2'h0, 1'b1);
    chk1(1'b0, eventIrq);
    readPend;
    drop(RSN_NO_DEST, 2'h1, 1'b0);
    drop(RSN_NO_DESCR, 2'h2, 1'b0);
    drop(RSN_BCAST_LEVEL, 2'h0, 1'b1);
    axr(A_EVST);
    chk32(32'h3, got);
    readPend;
    // Drop while clock enable is low is not taken
    ce <= 1'b0;
    dropValid <= 1'b1;
    dropReason <= RSN_RED;
    @(posedge clk);
    ce <= 1'b1;
    dropValid <= 1'b0;
    @(posedge clk);
    readPend;
    // Drop in the clearing read cycle lands in A
    drop(RSN_RED, 2'h0, 1'b1);
    fork
      axr(A_PEND);
      drop(RSN_YELLOW, 2'h2, 1'b1);
    join
    chk32(put('0, RSN_RED, 2'h0), got);
    model = put('0, RSN_YELLOW, 2'h2);
    readPend;
    // Reset in mid-run
    drop(RSN_NO_BUFFER, 2'h1, 1'b1);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    model = '0;
    @(posedge clk);
    axr(A_MASK);
    chk32(32'h1, got);
    readPend;
    summarize;
  end
endmodule : tb
